// File: common/int_ctrl_defs.svh
// Register offsets, field positions and reset values of the interrupt controller
`ifndef INT_CTRL_DEFS_SVH
`define INT_CTRL_DEFS_SVH

`define INT_CTRL_ADDR_W        8
`define INT_CTRL_DATA_W        16
`define INT_CTRL_NUM_SRC       20
`define INT_CTRL_NUM_CFG       10
`define INT_CTRL_LEVEL_W       3
`define INT_CTRL_VEC_W         5
`define INT_CTRL_IDX_W         5

// Level configuration registers, two bytes apart
`define INT_CTRL_CFG_BASE      8'h00
`define INT_CTRL_CFG_STRIDE    8'h02
`define INT_CTRL_CFG_LAST      8'h12
// Status, enable and clear of the controller's own events
`define INT_CTRL_EVT_STAT      8'h20
`define INT_CTRL_EVT_EN        8'h22
`define INT_CTRL_EVT_CLR       8'h24
// Presented request and pending snapshot
`define INT_CTRL_PRESENT       8'h26
`define INT_CTRL_PEND_LO       8'h28
`define INT_CTRL_PEND_HI       8'h2a

// Field layout of a level configuration register
`define INT_CTRL_ODD_LSB       8
`define INT_CTRL_ODD_MSB       10
`define INT_CTRL_EVEN_LSB      0
`define INT_CTRL_EVEN_MSB      2
`define INT_CTRL_LEVEL_RST     3'h0

// Event bits
`define INT_CTRL_EVT_ACCEPT    0
`define INT_CTRL_EVT_REPLACE   1
`define INT_CTRL_EVT_WITHDRAW  2
`define INT_CTRL_EVT_W         3
`define INT_CTRL_EVT_RST       3'h0

// Presented register layout
`define INT_CTRL_PRES_REQ      15
`define INT_CTRL_PRES_LVL_LSB  8
`define INT_CTRL_PRES_VEC_LSB  0

`endif

// File: common/int_ctrl_pkg.sv
// Types shared by the interrupt controller modules
package int_ctrl_pkg;

    typedef logic [2:0]  level_t;
    typedef logic [4:0]  vector_t;
    typedef logic [4:0]  src_idx_t;
    typedef logic [15:0] reg_word_t;

endpackage

// File: hdl/level_cfg_reg.sv
// One level configuration register holding two source levels
`timescale 1ns/1ps
`include "int_ctrl_defs.svh"

module level_cfg_reg (
    input  wire logic                    ref_clk_i,
    input  wire logic                    rst_i,
    input  wire logic                    wr_en_i,
    input  wire int_ctrl_pkg::reg_word_t wdata_i,
    output int_ctrl_pkg::level_t         odd_source_level_o,
    output int_ctrl_pkg::level_t         even_source_level_o,
    output int_ctrl_pkg::reg_word_t      rdata_o
);

    int_ctrl_pkg::level_t odd_q;
    int_ctrl_pkg::level_t odd_d;
    int_ctrl_pkg::level_t even_q;
    int_ctrl_pkg::level_t even_d;

    // R13 reserved writes ignored
    always_comb begin
        odd_d  = odd_q;
        even_d = even_q;
        if (wr_en_i) begin
            odd_d  = wdata_i[`INT_CTRL_ODD_MSB:`INT_CTRL_ODD_LSB];
            even_d = wdata_i[`INT_CTRL_EVEN_MSB:`INT_CTRL_EVEN_LSB];
        end
    end

    // R3 cleared at reset
    always_ff @(posedge ref_clk_i) begin
        if (rst_i) begin
            odd_q  <= `INT_CTRL_LEVEL_RST;
            even_q <= `INT_CTRL_LEVEL_RST;
        end else begin
            odd_q  <= odd_d;
            even_q <= even_d;
        end
    end

    assign odd_source_level_o  = odd_q;
    assign even_source_level_o = even_q;

    // R1 reserved bits read zero
    always_comb begin
        rdata_o = '0;
        rdata_o[`INT_CTRL_ODD_MSB:`INT_CTRL_ODD_LSB]   = odd_q;
        rdata_o[`INT_CTRL_EVEN_MSB:`INT_CTRL_EVEN_LSB] = even_q;
    end

endmodule

// File: hdl/level_arbiter.sv
// Picks the pending source with the highest level, lowest index on a tie
`timescale 1ns/1ps

module level_arbiter #(
    parameter int NUM_SRC = 20
) (
    input  wire logic [NUM_SRC-1:0]   pending_i,
    input  wire logic [NUM_SRC*3-1:0] levels_i,
    output logic                      valid_o,
    output int_ctrl_pkg::src_idx_t    idx_o,
    output int_ctrl_pkg::level_t      level_o
);

    // R9 highest level wins
    always_comb begin
        valid_o = 1'b0;
        idx_o   = '0;
        level_o = '0;
        for (int i = 0; i < NUM_SRC; i++) begin
            // Strict compare keeps the lower index on equal levels
            if (pending_i[i] && (!valid_o || levels_i[i*3 +: 3] > level_o)) begin
                valid_o = 1'b1;
                idx_o   = 5'(i);
                level_o = levels_i[i*3 +: 3];
            end
        end
    end

endmodule

// File: hdl/int_ctrl.sv
// Interrupt controller: level configuration, arbitration and CPU request
`timescale 1ns/1ps
`include "int_ctrl_defs.svh"

// Function
// R1 - Each level register is 16 bits, odd source in bits 10..8, even in 2..0, rest read 0.
// R2 - A level field is the priority itself, seven highest and zero lowest.
// R3 - All level fields are read/write and clear to zero at reset.
// R4 - Ten level registers serve twenty sources, two per register.
// R5 - Sources 0..4 are supply detect, port, power gen, clock gen and real-time clock.
// R6 - Sources 5..9 are timer 0, UART 0, timer 1, sync serial 0 and I2C.
// R7 - Sources 10..15 are PWM timer 0 and 1, UART 1, timer 2, sound gen and LCD driver.
// R8 - Sources 16..19 are the R/F converter channels 0..3.
// R9 - Among pending requests the highest level wins, lowest vector on a tie, others held.
// R10 - A pending request drives request, its level and its fixed vector to the CPU.
// R11 - A higher request replaces the unaccepted one, which stays held until its flag clears.
// R12 - The CPU never accepts a level zero request, so such a source is masked; the controller still presents it and the CPU refuses it.
// R13 - Levels are reached over the 16-bit register port and reserved writes are ignored.
module int_ctrl #(
    parameter int                    NUM_SRC  = `INT_CTRL_NUM_SRC,
    parameter int                    NUM_CFG  = `INT_CTRL_NUM_CFG,
    parameter int_ctrl_pkg::vector_t VEC_BASE = 5'h04
) (
    input  wire logic                    ref_clk_i,
    input  wire logic                    rst_i,
    input  wire logic [7:0]              reg_addr_i,
    input  wire int_ctrl_pkg::reg_word_t reg_wdata_i,
    input  wire logic                    reg_wr_i,
    input  wire logic                    reg_rd_i,
    output int_ctrl_pkg::reg_word_t      reg_rdata_o,
    input  wire logic                    supply_detect_irq_i,
    input  wire logic                    port_irq_i,
    input  wire logic                    power_gen_irq_i,
    input  wire logic                    clock_gen_irq_i,
    input  wire logic                    rtc_irq_i,
    input  wire logic                    timer0_irq_i,
    input  wire logic                    uart0_irq_i,
    input  wire logic                    timer1_irq_i,
    input  wire logic                    sync_serial0_irq_i,
    input  wire logic                    i2c0_irq_i,
    input  wire logic                    pwm_timer0_irq_i,
    input  wire logic                    pwm_timer1_irq_i,
    input  wire logic                    uart1_irq_i,
    input  wire logic                    timer2_irq_i,
    input  wire logic                    sound_gen_irq_i,
    input  wire logic                    lcd_driver_irq_i,
    input  wire logic                    rf_conv0_irq_i,
    input  wire logic                    rf_conv1_irq_i,
    input  wire logic                    rf_conv2_irq_i,
    input  wire logic                    rf_conv3_irq_i,
    input  wire logic                    cpu_ack_i,
    output logic                         cpu_req_o,
    output int_ctrl_pkg::level_t         cpu_level_o,
    output int_ctrl_pkg::vector_t        cpu_vector_o,
    output logic                         irq_o
);

    logic [NUM_SRC-1:0]               src_req;
    logic [NUM_SRC*3-1:0]             levels;
    logic [NUM_CFG-1:0]               cfg_wr;
    int_ctrl_pkg::reg_word_t          cfg_rdata [NUM_CFG];
    logic [NUM_SRC-1:0]               pending;
    logic [NUM_SRC-1:0]               ack_onehot;
    logic                             win_valid;
    int_ctrl_pkg::src_idx_t           win_idx;
    int_ctrl_pkg::level_t             win_level;

    logic [NUM_SRC-1:0]               accepted_q;
    logic [NUM_SRC-1:0]               accepted_d;
    logic                             req_q;
    logic                             req_d;
    int_ctrl_pkg::level_t             level_q;
    int_ctrl_pkg::level_t             level_d;
    int_ctrl_pkg::vector_t            vec_q;
    int_ctrl_pkg::vector_t            vec_d;
    int_ctrl_pkg::src_idx_t           idx_q;
    int_ctrl_pkg::src_idx_t           idx_d;

    logic [`INT_CTRL_EVT_W-1:0]       evt_set;
    logic [`INT_CTRL_EVT_W-1:0]       evt_stat_q;
    logic [`INT_CTRL_EVT_W-1:0]       evt_stat_d;
    logic [`INT_CTRL_EVT_W-1:0]       evt_en_q;
    logic [`INT_CTRL_EVT_W-1:0]       evt_en_d;
    int_ctrl_pkg::reg_word_t          rdata_q;
    int_ctrl_pkg::reg_word_t          rdata_d;

    // R5 source order, low part
    assign src_req[0]  = supply_detect_irq_i;
    assign src_req[1]  = port_irq_i;
    assign src_req[2]  = power_gen_irq_i;
    assign src_req[3]  = clock_gen_irq_i;
    assign src_req[4]  = rtc_irq_i;
    // R6 source order, timers and serial
    assign src_req[5]  = timer0_irq_i;
    assign src_req[6]  = uart0_irq_i;
    assign src_req[7]  = timer1_irq_i;
    assign src_req[8]  = sync_serial0_irq_i;
    assign src_req[9]  = i2c0_irq_i;
    // R7 source order, upper peripherals
    assign src_req[10] = pwm_timer0_irq_i;
    assign src_req[11] = pwm_timer1_irq_i;
    assign src_req[12] = uart1_irq_i;
    assign src_req[13] = timer2_irq_i;
    assign src_req[14] = sound_gen_irq_i;
    assign src_req[15] = lcd_driver_irq_i;
    // R8 converter channels ascending
    assign src_req[16] = rf_conv0_irq_i;
    assign src_req[17] = rf_conv1_irq_i;
    assign src_req[18] = rf_conv2_irq_i;
    assign src_req[19] = rf_conv3_irq_i;

    // R4 ten registers, two sources each
    for (genvar g = 0; g < NUM_CFG; g++) begin : g_cfg
        assign cfg_wr[g] = reg_wr_i &&
            (reg_addr_i == 8'(`INT_CTRL_CFG_BASE + g * `INT_CTRL_CFG_STRIDE));

        level_cfg_reg u_cfg (
            .ref_clk_i           (ref_clk_i),
            .rst_i               (rst_i),
            .wr_en_i             (cfg_wr[g]),
            .wdata_i             (reg_wdata_i),
            .odd_source_level_o  (levels[(2*g+1)*3 +: 3]),
            .even_source_level_o (levels[(2*g)*3 +: 3]),
            .rdata_o             (cfg_rdata[g])
        );
    end

    // Source just accepted leaves arbitration at once
    always_comb begin
        ack_onehot = '0;
        if (cpu_ack_i && req_q) begin
            ack_onehot[idx_q] = 1'b1;
        end
    end

    // R9 accepted sources held out until serviced
    assign pending = src_req & ~accepted_q & ~ack_onehot;

    // R2 level used directly as priority
    level_arbiter #(
        .NUM_SRC (NUM_SRC)
    ) u_arb (
        .pending_i (pending),
        .levels_i  (levels),
        .valid_o   (win_valid),
        .idx_o     (win_idx),
        .level_o   (win_level)
    );

    // Accept mark drops when the peripheral flag clears, so a
    // still-set flag cannot re-interrupt the handler forever
    always_comb begin
        accepted_d = (accepted_q | ack_onehot) & src_req;
    end

    // R10 request, level and vector follow the winner
    // R11 newer higher request replaces presented one
    always_comb begin
        req_d   = win_valid;
        level_d = win_valid ? win_level : '0;
        idx_d   = win_valid ? win_idx : '0;
        vec_d   = win_valid ? 5'(VEC_BASE + win_idx) : '0;
    end

    always_ff @(posedge ref_clk_i) begin
        if (rst_i) begin
            accepted_q <= '0;
            req_q      <= 1'b0;
            level_q    <= '0;
            idx_q      <= '0;
            vec_q      <= '0;
        end else begin
            accepted_q <= accepted_d;
            req_q      <= req_d;
            level_q    <= level_d;
            idx_q      <= idx_d;
            vec_q      <= vec_d;
        end
    end

    // R12 level zero still shown; the CPU refuses it
    assign cpu_req_o    = req_q;
    assign cpu_level_o  = level_q;
    assign cpu_vector_o = vec_q;

    // Controller events
    always_comb begin
        evt_set = '0;
        evt_set[`INT_CTRL_EVT_ACCEPT]   = cpu_ack_i && req_q;
        // R11 replacement before acceptance
        evt_set[`INT_CTRL_EVT_REPLACE]  = req_q && !cpu_ack_i && win_valid &&
                                          (win_idx != idx_q);
        evt_set[`INT_CTRL_EVT_WITHDRAW] = req_q && !cpu_ack_i && !win_valid;
    end

    // Set wins over a clear in the same cycle
    always_comb begin
        evt_stat_d = evt_stat_q;
        evt_en_d   = evt_en_q;
        if (reg_wr_i && reg_addr_i == `INT_CTRL_EVT_CLR) begin
            evt_stat_d = evt_stat_q & ~reg_wdata_i[`INT_CTRL_EVT_W-1:0];
        end
        if (reg_wr_i && reg_addr_i == `INT_CTRL_EVT_EN) begin
            evt_en_d = reg_wdata_i[`INT_CTRL_EVT_W-1:0];
        end
        evt_stat_d = evt_stat_d | evt_set;
    end

    always_ff @(posedge ref_clk_i) begin
        if (rst_i) begin
            evt_stat_q <= `INT_CTRL_EVT_RST;
            evt_en_q   <= `INT_CTRL_EVT_RST;
        end else begin
            evt_stat_q <= evt_stat_d;
            evt_en_q   <= evt_en_d;
        end
    end

    assign irq_o = |(evt_stat_q & evt_en_q);

    // Read path, one cycle latency, unmapped reads zero
    always_comb begin
        rdata_d = '0;
        if (reg_rd_i) begin
            for (int i = 0; i < NUM_CFG; i++) begin
                if (reg_addr_i == 8'(`INT_CTRL_CFG_BASE + i * `INT_CTRL_CFG_STRIDE)) begin
                    rdata_d = cfg_rdata[i];
                end
            end
            case (reg_addr_i)
                `INT_CTRL_EVT_STAT: begin
                    rdata_d[`INT_CTRL_EVT_W-1:0] = evt_stat_q;
                end
                `INT_CTRL_EVT_EN: begin
                    rdata_d[`INT_CTRL_EVT_W-1:0] = evt_en_q;
                end
                `INT_CTRL_PRESENT: begin
                    rdata_d[`INT_CTRL_PRES_REQ] = req_q;
                    rdata_d[`INT_CTRL_PRES_LVL_LSB +: 3] = level_q;
                    rdata_d[`INT_CTRL_PRES_VEC_LSB +: 5] = vec_q;
                end
                `INT_CTRL_PEND_LO: begin
                    rdata_d = src_req[15:0];
                end
                `INT_CTRL_PEND_HI: begin
                    rdata_d[NUM_SRC-17:0] = src_req[NUM_SRC-1:16];
                end
                default: begin
                end
            endcase
        end
    end

    always_ff @(posedge ref_clk_i) begin
        if (rst_i) begin
            rdata_q <= '0;
        end else begin
            rdata_q <= rdata_d;
        end
    end

    assign reg_rdata_o = rdata_q;

endmodule

// File: verif/int_ctrl_chk.sv
// Port assertions for the interrupt controller
`timescale 1ns/1ps
module int_ctrl_chk #(
    parameter int                    NUM_SRC  = 20,
    parameter int_ctrl_pkg::vector_t VEC_BASE = 5'h04
) (
    input wire logic                    ref_clk_i,
    input wire logic                    rst_i,
    input wire logic [7:0]              reg_addr_i,
    input wire int_ctrl_pkg::reg_word_t reg_wdata_i,
    input wire logic                    reg_wr_i,
    input wire logic                    reg_rd_i,
    input wire int_ctrl_pkg::reg_word_t reg_rdata_o,
    input wire logic                    timer0_irq_i,
    input wire logic                    cpu_ack_i,
    input wire logic                    cpu_req_o,
    input wire int_ctrl_pkg::level_t    cpu_level_o,
    input wire int_ctrl_pkg::vector_t   cpu_vector_o
);
    default clocking @(posedge ref_clk_i); endclocking
    default disable iff (rst_i);
    sequence s_wr_rd;
        (reg_wr_i && reg_addr_i <= 8'h12 && !reg_addr_i[0]) ##1 (reg_rd_i && $stable(reg_addr_i));
    endsequence
    sequence s_t0_held;
        cpu_req_o && !cpu_ack_i && timer0_irq_i && cpu_vector_o == VEC_BASE + 5'd5;
    endsequence
    a_wr_rd_back: assert property (
        s_wr_rd |=> reg_rdata_o == ($past(reg_wdata_i, 2) & 16'h0707))
        else $error("level readback wrong");
    a_rsv_read_zero: assert property (
        reg_rd_i && reg_addr_i <= 8'h12 |=> (reg_rdata_o & 16'hf8f8) == 16'h0000)
        else $error("reserved bits not zero");
    a_unmapped_zero: assert property (
        reg_rd_i && reg_addr_i > 8'h2a |=> reg_rdata_o == 16'h0000)
        else $error("unmapped read not zero");
    a_rdata_idle: assert property (
        !reg_rd_i |=> reg_rdata_o == 16'h0000)
        else $error("read data without read");
    a_idle_outs_zero: assert property (
        !cpu_req_o |-> cpu_level_o == 3'h0 && cpu_vector_o == 5'h00)
        else $error("level or vector without request");
    a_vector_in_range: assert property (
        cpu_req_o |-> cpu_vector_o >= VEC_BASE && cpu_vector_o - VEC_BASE < NUM_SRC)
        else $error("vector out of range");
    a_rise_presents: assert property (
        $rose(timer0_irq_i) && !cpu_req_o |=> cpu_req_o)
        else $error("request not presented");
    a_held_stays: assert property (
        s_t0_held |=> cpu_req_o)
        else $error("held request lost");
    a_ack_excludes: assert property (
        cpu_ack_i && cpu_vector_o == VEC_BASE + 5'd5 && timer0_irq_i
        |=> cpu_vector_o != VEC_BASE + 5'd5)
        else $error("accepted source presented again");
endmodule

bind int_ctrl int_ctrl_chk #(.NUM_SRC(NUM_SRC), .VEC_BASE(VEC_BASE)) u_int_ctrl_chk (
    .ref_clk_i, .rst_i, .reg_addr_i, .reg_wdata_i, .reg_wr_i, .reg_rd_i, .reg_rdata_o,
    .timer0_irq_i, .cpu_ack_i, .cpu_req_o, .cpu_level_o, .cpu_vector_o);

// File: verif/cpu_model.sv
// Behavioural CPU that accepts presented interrupt requests
`timescale 1ns/1ps
module cpu_model (
    input  wire logic                  ref_clk_i,
    input  wire logic                  rst_i,
    input  wire logic                  enable_i,
    input  wire int_ctrl_pkg::level_t  min_level_i,
    input  wire logic [3:0]            delay_i,
    input  wire logic                  cpu_req_i,
    input  wire int_ctrl_pkg::level_t  cpu_level_i,
    input  wire int_ctrl_pkg::vector_t cpu_vector_i,
    output logic                       cpu_ack_o,
    output int_ctrl_pkg::vector_t      last_vector_o
);
    logic [3:0] wait_q;
    // strict compare keeps level zero masked
    always_ff @(posedge ref_clk_i) begin
        cpu_ack_o <= 1'b0;
        if (rst_i) begin
            wait_q <= 4'h0;
            last_vector_o <= 5'h00;
        end else if (enable_i && cpu_req_i && !cpu_ack_o && cpu_level_i > min_level_i) begin
            if (wait_q >= delay_i) begin
                cpu_ack_o <= 1'b1;
                last_vector_o <= cpu_vector_i;
                wait_q <= 4'h0;
            end else begin
                wait_q <= wait_q + 4'h1;
            end
        end else begin
            wait_q <= 4'h0;
        end
    end
endmodule

// File: verif/test_int_ctrl.sv
// Self-checking bench for the interrupt controller
`timescale 1ns/1ps
module test_int_ctrl;
    localparam int_ctrl_pkg::vector_t VB = 5'h04;
    logic                    ref_clk_i = 1'b0;
    logic                    rst_i = 1'b1;
    logic [7:0]              reg_addr_i = 8'h00;
    int_ctrl_pkg::reg_word_t reg_wdata_i = 16'h0000;
    logic                    reg_wr_i = 1'b0;
    logic                    reg_rd_i = 1'b0;
    int_ctrl_pkg::reg_word_t reg_rdata_o, rv;
    logic [19:0]             src = 20'h0;
    logic                    ack, req, irq;
    logic                    m_en = 1'b0;
    logic [3:0]              m_dly = 4'h3;
    int_ctrl_pkg::level_t    lvl;
    int_ctrl_pkg::vector_t   vec, last_vec;
    int                      err_total = 0;
    int                      compares = 0;

    always #10 ref_clk_i = ~ref_clk_i;

    int_ctrl #(.VEC_BASE(VB)) u_int_ctrl (
        .ref_clk_i, .rst_i, .reg_addr_i, .reg_wdata_i, .reg_wr_i, .reg_rd_i, .reg_rdata_o,
        .supply_detect_irq_i(src[0]), .port_irq_i(src[1]), .power_gen_irq_i(src[2]),
        .clock_gen_irq_i(src[3]), .rtc_irq_i(src[4]), .timer0_irq_i(src[5]),
        .uart0_irq_i(src[6]), .timer1_irq_i(src[7]), .sync_serial0_irq_i(src[8]),
        .i2c0_irq_i(src[9]), .pwm_timer0_irq_i(src[10]), .pwm_timer1_irq_i(src[11]),
        .uart1_irq_i(src[12]), .timer2_irq_i(src[13]), .sound_gen_irq_i(src[14]),
        .lcd_driver_irq_i(src[15]), .rf_conv0_irq_i(src[16]), .rf_conv1_irq_i(src[17]),
        .rf_conv2_irq_i(src[18]), .rf_conv3_irq_i(src[19]), .cpu_ack_i(ack),
        .cpu_req_o(req), .cpu_level_o(lvl), .cpu_vector_o(vec), .irq_o(irq));
    cpu_model u_cpu_model (.ref_clk_i, .rst_i, .enable_i(m_en), .min_level_i(3'h0),
        .delay_i(m_dly), .cpu_req_i(req), .cpu_level_i(lvl), .cpu_vector_i(vec),
        .cpu_ack_o(ack), .last_vector_o(last_vec));

    task automatic finish_test;
        $display("compares=%0d err_total=%0d", compares, err_total);
        if (err_total == 0 && compares > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask

    task automatic check(input string nm, input logic [15:0] seen, input logic [15:0] exp);
        compares++;
        if (seen !== exp) begin
            err_total++;
            $display("[ERR] %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    task automatic rd(input logic [7:0] a);
        reg_addr_i <= a;
        reg_rd_i <= 1'b1;
        @(posedge ref_clk_i);
        reg_rd_i <= 1'b0;
        @(negedge ref_clk_i);
        rv = reg_rdata_o;
        @(posedge ref_clk_i);
    endtask

    // Every write is read straight back, so strobes never collide
    task automatic wr(input logic [7:0] a, input int_ctrl_pkg::reg_word_t d);
        reg_addr_i <= a;
        reg_wdata_i <= d;
        reg_wr_i <= 1'b1;
        @(posedge ref_clk_i);
        reg_wr_i <= 1'b0;
        rd(a);
    endtask

    task automatic present(input logic [19:0] m, input int_ctrl_pkg::vector_t v,
                           input int_ctrl_pkg::level_t l);
        src <= m;
        @(posedge ref_clk_i);
        @(negedge ref_clk_i);
        check("req", req, 16'h1);
        check("vec", vec, v);
        check("lvl", lvl, l);
        @(posedge ref_clk_i);
    endtask

    task automatic wait_ack;
        int n;
        n = 0;
        @(negedge ref_clk_i);
        while (ack !== 1'b1 && n < 20) begin
            @(negedge ref_clk_i);
            n++;
        end
        // Late ack on the last poll still counts as an ack
        if (ack !== 1'b1) begin
            err_total++;
            finish_test;
        end
        @(posedge ref_clk_i);
    endtask

    initial begin
        repeat (3) @(posedge ref_clk_i);
        rst_i <= 1'b0;
        for (int i = 0; i < 10; i++) begin
            rd(8'(2 * i));
            check("rst_lvl", rv, 16'h0000);
            wr(8'(2 * i), 16'hffff);
            check("rsv_bits", rv, 16'h0707);
            wr(8'(2 * i), 16'h0101);
            check("lvl_rw", rv, 16'h0101);
        end
        rd(8'h40);
        check("unmapped", rv, 16'h0000);
        for (int i = 0; i < 20; i++) begin
            present(20'(1) << i, VB + 5'(i), 3'h1);
            rd(i < 16 ? 8'h28 : 8'h2a);
            check("pend", rv, 16'(1 << (i % 16)));
            src <= 20'h0;
            @(posedge ref_clk_i);
        end
        for (int l = 0; l < 8; l++) begin
            wr(8'h04, {8'(l), 8'h04});
            present(20'h00030, l > 4 ? VB + 5'd5 : VB + 5'd4, l > 4 ? 3'(l) : 3'h4);
            src <= 20'h0;
            @(posedge ref_clk_i);
        end
        wr(8'h06, 16'h0006);
        present(20'h00010, VB + 5'd4, 3'h4);
        present(20'h00050, VB + 5'd6, 3'h6);
        present(20'h00070, VB + 5'd5, 3'h7);
        src <= 20'h0;
        wr(8'h04, 16'h0000);
        wr(8'h08, 16'h0500);
        rd(8'h20);
        check("evt_repl", rv, 16'h0006);
        wr(8'h24, 16'h0007);
        m_en <= 1'b1;
        src <= 20'h00220;
        wait_ack;
        check("acc_vec", last_vec, VB + 5'd9);
        repeat (8) @(posedge ref_clk_i);
        present(20'h00220, VB + 5'd5, 3'h0);
        check("no_acc", last_vec, VB + 5'd9);
        rd(8'h26);
        check("presented", rv, {8'h80, 3'h0, VB + 5'd5});
        src <= 20'h00200;
        @(posedge ref_clk_i);
        @(negedge ref_clk_i);
        check("dropped", req, 16'h0);
        @(posedge ref_clk_i);
        rd(8'h20);
        check("events", rv & 16'h0005, 16'h0005);
        src <= 20'h0;
        m_dly <= 4'h0;
        wr(8'h04, 16'h0200);
        src <= 20'h00020;
        wait_ack;
        check("acc_t0", last_vec, VB + 5'd5);
        @(negedge ref_clk_i);
        check("excluded", req, 16'h0);
        @(posedge ref_clk_i);
        src <= 20'h0;
        wr(8'h22, 16'h0001);
        @(negedge ref_clk_i);
        check("irq_set", irq, 16'h1);
        @(posedge ref_clk_i);
        wr(8'h24, 16'h0007);
        @(negedge ref_clk_i);
        check("irq_clr", irq, 16'h0);
        @(posedge ref_clk_i);
        finish_test;
    end
endmodule
